// ===== hw/nfc_host.sv
// host controller driving an asynchronous parallel nor flash over its pins
`timescale 1ns/1ps
module nfc_host (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire nfc_pkg::nfc_op_t cmd_op,
    input wire logic [nfc_pkg::AW-1:0] cmd_addr,
    input wire logic [nfc_pkg::DW-1:0] cmd_wdata,
    output logic rsp_valid,
    output logic [nfc_pkg::DW-1:0] rsp_data,
    output logic [nfc_pkg::AW-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_byte_n,
    input wire logic [nfc_pkg::DW-1:0] flash_dq_in,
    output logic [nfc_pkg::DW-1:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic id_voltage_addr_en,
    output logic id_voltage_reset_en
);
    typedef enum logic [3:0] {
        ST_RST_START, ST_RST_LOW, ST_RST_REC, ST_IDLE, ST_RD_WAIT,
        ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_PR_SETUP, ST_PR_PULSE, ST_PR_HOLD
    } nfc_state_t;

    localparam int AW = nfc_pkg::AW;
    localparam int DW = nfc_pkg::DW;
    localparam int PAGE_LSB_IDX = nfc_pkg::PAGE_LSB;

    nfc_tmr_if tif ();
    nfc_timer u_timer (.clock(clock), .resetn(resetn), .t(tif));

    nfc_state_t state_q, state_d;
    nfc_pkg::nfc_op_t op_q, op_d;
    logic [1:0] step_q, step_d;
    logic [AW-1:0] addr_q, addr_d, ua_q, ua_d;
    logic [DW-1:0] dout_q, dout_d, ud_q, ud_d, rdata_q, rdata_d;
    logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, rst_n_q, rst_n_d;
    logic dq_oe_q, dq_oe_d, ahv_q, ahv_d, rhv_q, rhv_d, rvalid_q, rvalid_d;
    logic [AW-1:PAGE_LSB_IDX] page_q, page_d;
    logic page_ok_q, page_ok_d;
    logic [AW+DW:0] seq;
    logic take;
    logic hit;

    // command sequence per step: {last, address, data}
    function automatic logic [AW+DW:0] nfc_seq(nfc_pkg::nfc_op_t op, logic [1:0] step,
                                               logic [AW-1:0] ua, logic [DW-1:0] ud);
        logic [AW+DW:0] r;
        r = {1'b1, ua, ud};
        if (op == nfc_pkg::OP_ID_EXIT) begin
            r = {1'b1, ua, nfc_pkg::CMD_RESET};
        end else if (op == nfc_pkg::OP_ID_ENTER) begin
            if (step == nfc_pkg::STEP_FIRST) begin
                r = {1'b0, nfc_pkg::UNLOCK1_ADDR, nfc_pkg::UNLOCK1_DATA};
            end else if (step == nfc_pkg::STEP_SECOND) begin
                r = {1'b0, nfc_pkg::UNLOCK2_ADDR, nfc_pkg::UNLOCK2_DATA};
            end else begin
                r = {1'b1, nfc_pkg::UNLOCK1_ADDR, nfc_pkg::CMD_AUTOSELECT};
            end
        end
        return r;
    endfunction

    assign cmd_ready = (state_q == ST_IDLE);
    assign take = cmd_valid && cmd_ready;
    assign seq = nfc_seq(op_q, step_q, ua_q, ud_q);
    // fast page timing only for a plain read on the page last opened
    assign hit = page_ok_q && (cmd_op == nfc_pkg::OP_READ) && (cmd_addr[AW-1:PAGE_LSB_IDX] == page_q);

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        step_d = step_q;
        addr_d = addr_q;
        ua_d = ua_q;
        ud_d = ud_q;
        dout_d = dout_q;
        rdata_d = rdata_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        rst_n_d = rst_n_q;
        dq_oe_d = dq_oe_q;
        ahv_d = ahv_q;
        rhv_d = rhv_q;
        rvalid_d = 1'b0;
        page_d = page_q;
        page_ok_d = page_ok_q;
        tif.load = 1'b0;
        tif.count = nfc_pkg::ACC_CYC;
        unique case (state_q)
            ST_RST_START: begin
                // pin reset aborts the device; outputs float while low
                rst_n_d = 1'b0;
                ce_n_d = 1'b1;
                oe_n_d = 1'b1;
                we_n_d = 1'b1;
                dq_oe_d = 1'b0;
                ahv_d = 1'b0;
                rhv_d = 1'b0;
                page_ok_d = 1'b0;
                tif.load = 1'b1;
                tif.count = nfc_pkg::RST_CYC;
                state_d = ST_RST_LOW;
            end
            ST_RST_LOW: begin
                if (tif.expired) begin
                    rst_n_d = 1'b1;
                    tif.load = 1'b1;
                    tif.count = nfc_pkg::REC_CYC;
                    state_d = ST_RST_REC;
                end
            end
            ST_RST_REC: begin
                if (tif.expired) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (take) begin
                    op_d = cmd_op;
                    ua_d = cmd_addr;
                    ud_d = cmd_wdata;
                    step_d = nfc_pkg::STEP_FIRST;
                    unique case (cmd_op)
                        nfc_pkg::OP_READ, nfc_pkg::OP_HV_READ, nfc_pkg::OP_VERIFY: begin
                            addr_d = cmd_addr;
                            if (cmd_op == nfc_pkg::OP_VERIFY) begin
                                addr_d = {cmd_addr[AW-1:nfc_pkg::GRP_LSB],
                                          {(nfc_pkg::GRP_LSB - nfc_pkg::LOW_W){1'b0}},
                                          nfc_pkg::PROT_LOW_BITS};
                            end
                            // high voltage on the id line only for id and verify reads
                            ahv_d = (cmd_op != nfc_pkg::OP_READ);
                            ce_n_d = 1'b0;
                            oe_n_d = 1'b0;
                            dq_oe_d = 1'b0;
                            tif.load = 1'b1;
                            tif.count = hit ? nfc_pkg::PAGE_CYC : nfc_pkg::ACC_CYC;
                            state_d = ST_RD_WAIT;
                        end
                        nfc_pkg::OP_WRITE, nfc_pkg::OP_ID_ENTER, nfc_pkg::OP_ID_EXIT: begin
                            ahv_d = 1'b0;
                            page_ok_d = 1'b0;
                            state_d = ST_WR_SETUP;
                        end
                        nfc_pkg::OP_PROTECT: begin
                            page_ok_d = 1'b0;
                            state_d = ST_PR_SETUP;
                        end
                        nfc_pkg::OP_UNPROT_ON: begin
                            rhv_d = 1'b1;
                        end
                        nfc_pkg::OP_UNPROT_OFF: begin
                            rhv_d = 1'b0;
                        end
                        nfc_pkg::OP_HW_RESET: begin
                            state_d = ST_RST_START;
                        end
                        default: begin
                            state_d = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_RD_WAIT: begin
                // address and gates stay put; the device may sleep and keep its data
                if (tif.expired) begin
                    rdata_d = flash_dq_in;
                    rvalid_d = 1'b1;
                    page_d = addr_q[AW-1:PAGE_LSB_IDX];
                    page_ok_d = !ahv_q;
                    state_d = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                // gate high one cycle before driving the bus avoids contention
                addr_d = seq[AW+DW-1:DW];
                dout_d = seq[DW-1:0];
                ce_n_d = 1'b0;
                oe_n_d = 1'b1;
                state_d = ST_WR_PULSE;
            end
            ST_WR_PULSE: begin
                we_n_d = 1'b0;
                dq_oe_d = 1'b1;
                tif.load = we_n_q;
                tif.count = nfc_pkg::WE_CYC;
                if (!we_n_q && tif.expired) begin
                    we_n_d = 1'b1;
                    state_d = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                dq_oe_d = 1'b0;
                if (seq[AW+DW]) begin
                    ce_n_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    step_d = step_q + 1'b1;
                    state_d = ST_WR_SETUP;
                end
            end
            ST_PR_SETUP: begin
                ahv_d = 1'b1;
                addr_d = {ua_q[AW-1:nfc_pkg::GRP_LSB], {(nfc_pkg::GRP_LSB - nfc_pkg::LOW_W){1'b0}},
                          nfc_pkg::PROT_LOW_BITS};
                ce_n_d = 1'b0;
                oe_n_d = 1'b0;
                dq_oe_d = 1'b0;
                tif.load = 1'b1;
                tif.count = nfc_pkg::PROT_SETUP_CYC;
                state_d = ST_PR_PULSE;
            end
            ST_PR_PULSE: begin
                if (we_n_q && tif.expired) begin
                    we_n_d = 1'b0;
                    tif.load = 1'b1;
                    tif.count = nfc_pkg::PROT_PULSE_CYC;
                end else if (!we_n_q && tif.expired) begin
                    we_n_d = 1'b1;
                    state_d = ST_PR_HOLD;
                end
            end
            ST_PR_HOLD: begin
                ahv_d = 1'b0;
                ce_n_d = 1'b1;
                oe_n_d = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_RST_START;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= ST_RST_START;
            op_q <= nfc_pkg::OP_READ;
            step_q <= nfc_pkg::STEP_FIRST;
            addr_q <= '0;
            ua_q <= '0;
            ud_q <= '0;
            dout_q <= '0;
            rdata_q <= '0;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            rst_n_q <= 1'b0;
            dq_oe_q <= 1'b0;
            ahv_q <= 1'b0;
            rhv_q <= 1'b0;
            rvalid_q <= 1'b0;
            page_q <= '0;
            page_ok_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            step_q <= step_d;
            addr_q <= addr_d;
            ua_q <= ua_d;
            ud_q <= ud_d;
            dout_q <= dout_d;
            rdata_q <= rdata_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            rst_n_q <= rst_n_d;
            dq_oe_q <= dq_oe_d;
            ahv_q <= ahv_d;
            rhv_q <= rhv_d;
            rvalid_q <= rvalid_d;
            page_q <= page_d;
            page_ok_q <= page_ok_d;
        end
    end

    assign flash_addr = addr_q;
    assign flash_ce_n = ce_n_q;
    assign flash_oe_n = oe_n_q;
    assign flash_we_n = we_n_q;
    assign flash_reset_n = rst_n_q;
    assign flash_byte_n = 1'b1;
    assign flash_dq_out = dout_q;
    assign flash_dq_oe = dq_oe_q;
    assign id_voltage_addr_en = ahv_q;
    assign id_voltage_reset_en = rhv_q;
    assign rsp_valid = rvalid_q;
    assign rsp_data = rdata_q;

    // helper: cycles the reset pin has been low
    logic [nfc_pkg::TW-1:0] low_cnt_q;
    always_ff @(posedge clock) begin
        if (!resetn || flash_reset_n) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != '1) begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    wr_strobe_a: assert property (!flash_we_n && !id_voltage_addr_en |-> !flash_ce_n && flash_oe_n)
        else $error("write strobe low without select low and gate high");
    rst_pulse_a: assert property ($rose(flash_reset_n) |-> low_cnt_q >= nfc_pkg::RST_CYC)
        else $error("reset pin pulse shorter than minimum");
    rst_rec_a: assert property ($rose(flash_reset_n) |-> flash_oe_n [*2])
        else $error("read gate opened inside reset recovery");
    bus_drive_a: assert property (flash_dq_oe |-> flash_oe_n && flash_reset_n)
        else $error("host drives data while device gate is low");
    wr_hold_a: assert property (!flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
        else $error("address or data moved during write strobe");
    prot_pins_a: assert property (!flash_we_n && id_voltage_addr_en |->
                                  !flash_ce_n && !flash_oe_n &&
                                  flash_addr[nfc_pkg::LOW_W-1:0] == nfc_pkg::PROT_LOW_BITS)
        else $error("protect strobe with wrong control or address pattern");
    rd_stable_a: assert property (state_q == ST_RD_WAIT && $past(state_q == ST_RD_WAIT) |-> $stable(flash_addr))
        else $error("address changed during read wait");
    rd_gate_a: assert property (rsp_valid |-> $past(!flash_ce_n && !flash_oe_n) && $past(!flash_ce_n, 2))
        else $error("read data taken without select and gate low");

    rd_done_c: cover property (rsp_valid && !id_voltage_addr_en);
    page_hit_c: cover property (take && hit);
    prot_pulse_c: cover property ($rose(flash_we_n) && id_voltage_addr_en);
    id_enter_c: cover property (state_q == ST_WR_HOLD && op_q == nfc_pkg::OP_ID_ENTER && seq[AW+DW]);
    rst_done_c: cover property ($rose(flash_reset_n));
endmodule

// ===== hw/nfc_pkg.sv
// constants and types shared by the flash bus host controller
package nfc_pkg;
    localparam int CLK_MHZ = 10;
    localparam int AW = 22;
    localparam int DW = 16;
    localparam int TW = 10;
    localparam int GRP_LSB = 15;
    localparam int GRP_W = 7;
    localparam int LOW_W = 7;
    localparam int PAGE_LSB = 2;

    // times in ns
    localparam int ACCESS_TIME_NS = 90;
    localparam int PAGE_ACCESS_TIME_NS = 25;
    localparam int RESET_PULSE_MIN_NS = 500;
    localparam int RESET_RECOVERY_TIME_NS = 50;
    localparam int WE_PULSE_NS = 35;
    localparam int PROT_SETUP_NS = 4000;
    localparam int PROT_PULSE_NS = 100000;

    // least times, rounded up to whole cycles
    localparam logic [TW-1:0] ACC_CYC = TW'((ACCESS_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] PAGE_CYC = TW'((PAGE_ACCESS_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] RST_CYC = TW'((RESET_PULSE_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] REC_CYC = TW'((RESET_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] WE_CYC = TW'((WE_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] PROT_SETUP_CYC = TW'((PROT_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TW-1:0] PROT_PULSE_CYC = TW'((PROT_PULSE_NS * CLK_MHZ + 999) / 1000);

    // low address pattern A6,A3,A2,A1,A0 = 0,0,0,1,0 for protect and verify
    localparam logic [LOW_W-1:0] PROT_LOW_BITS = 7'h02;

    localparam logic [AW-1:0] UNLOCK1_ADDR = 22'h000555;
    localparam logic [AW-1:0] UNLOCK2_ADDR = 22'h0002AA;
    localparam logic [DW-1:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [DW-1:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [DW-1:0] CMD_AUTOSELECT = 16'h0090;
    localparam logic [DW-1:0] CMD_RESET = 16'h00F0;
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_SECOND = 2'h1;

    typedef enum logic [3:0] {
        OP_READ,
        OP_HV_READ,
        OP_VERIFY,
        OP_WRITE,
        OP_ID_ENTER,
        OP_ID_EXIT,
        OP_PROTECT,
        OP_UNPROT_ON,
        OP_UNPROT_OFF,
        OP_HW_RESET
    } nfc_op_t;
endpackage

// ===== hw/nfc_tmr_if.sv
// wait-timer link between the host sequencer and its timer
`timescale 1ns/1ps
interface nfc_tmr_if;
    logic load;
    logic [nfc_pkg::TW-1:0] count;
    logic expired;
    modport ctl (output load, output count, input expired);
    modport tmr (input load, input count, output expired);
endinterface

// ===== hw/nfc_timer.sv
// down-counting wait timer used for every pin timing
`timescale 1ns/1ps
module nfc_timer (
    input wire logic clock,
    input wire logic resetn,
    nfc_tmr_if.tmr t
);
    logic [nfc_pkg::TW-1:0] cnt_q;
    logic [nfc_pkg::TW-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (t.load) begin
            cnt_d = t.count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign t.expired = (cnt_q == '0);
endmodule

// ===== bench/nfc_flash_model.sv
// behavioural model of the nor flash device on the far side of the host
`timescale 1ns/1ps
module nfc_flash_model #(
    parameter logic [15:0] MAKER = 16'h00C1, // arbitrary
    parameter logic [15:0] DEVC = 16'h1B2D, // arbitrary
    parameter logic [15:0] EXT1 = 16'h0A11, // arbitrary
    parameter logic [15:0] EXT2 = 16'h0B22, // arbitrary
    parameter int REC_NS = 50
) (
    input wire logic [21:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic [15:0] dq_in,
    input wire logic hv_addr,
    output logic [15:0] dq
);
    logic [127:0] prot = '0;
    logic id_mode = 1'b0;
    logic [1:0] step = 2'h0;
    logic wr_open = 1'b0;
    logic prot_cyc = 1'b0;
    logic woke = 1'b1;
    logic drive;
    logic [21:0] lat_addr = '0;
    logic [15:0] val;
    logic [15:0] last = '0;

    task automatic take_cmd(input logic [21:0] a, input logic [7:0] d);
        if (d == nfc_pkg::CMD_RESET[7:0]) begin
            id_mode = 1'b0;
            step = 2'h0;
        end else if (step == 2'h0 && a == nfc_pkg::UNLOCK1_ADDR && d == nfc_pkg::UNLOCK1_DATA[7:0]) begin
            step = 2'h1;
        end else if (step == 2'h1 && a == nfc_pkg::UNLOCK2_ADDR && d == nfc_pkg::UNLOCK2_DATA[7:0]) begin
            step = 2'h2;
        end else if (step == 2'h2 && a == nfc_pkg::UNLOCK1_ADDR && d == nfc_pkg::CMD_AUTOSELECT[7:0]) begin
            id_mode = 1'b1;
            step = 2'h0;
        end else begin
            step = 2'h0;
        end
    endtask

    always @(negedge we_n or negedge ce_n) begin
        if (!we_n && !ce_n && reset_n) begin
            lat_addr = addr;
            wr_open = 1'b1;
            prot_cyc = hv_addr && !oe_n && addr[6:0] == nfc_pkg::PROT_LOW_BITS;
        end
    end

    always @(posedge we_n or posedge ce_n) begin
        if (wr_open) begin
            wr_open = 1'b0;
            // a group address that moved during the pulse protects nothing
            if (prot_cyc && addr[21:15] == lat_addr[21:15]) begin
                prot[lat_addr[21:15]] = 1'b1;
            end else if (!prot_cyc && oe_n) begin
                take_cmd(lat_addr, dq_in[7:0]);
            end
        end
    end

    // a write cut by reset is dropped, never half applied
    always @(negedge reset_n) begin
        id_mode = 1'b0;
        step = 2'h0;
        wr_open = 1'b0;
        woke = 1'b0;
    end

    always @(posedge reset_n) begin
        #(REC_NS);
        woke = 1'b1;
    end

    always @* begin
        drive = reset_n && woke && !ce_n && !oe_n && we_n;
        if (hv_addr && addr[6:0] == nfc_pkg::PROT_LOW_BITS) begin
            val = {15'h0000, prot[addr[21:15]]};
        end else if (hv_addr || id_mode) begin
            case (addr[3:0])
                4'h0: val = MAKER;
                4'h1: val = DEVC;
                4'hE: val = EXT1;
                4'hF: val = EXT2;
                default: val = 16'h0000;
            endcase
        end else begin
            val = addr[15:0] ^ 16'h5A3C;
        end
        if (drive) begin
            last = val;
        end
    end

    // released bus shows the inverse so a stale value never passes for a read
    assign dq = drive ? val : ~last;
endmodule

// ===== bench/tb.sv
// self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] MAKER = 16'h00C1; // arbitrary
    localparam logic [15:0] DEVC = 16'h1B2D; // arbitrary
    localparam logic [15:0] EXT1 = 16'h0A11; // arbitrary
    localparam logic [15:0] EXT2 = 16'h0B22; // arbitrary
    localparam logic [21:0] G5 = 22'h028000;
    localparam logic [21:0] G6 = 22'h030000;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    nfc_pkg::nfc_op_t cmd_op = nfc_pkg::OP_READ;
    logic [21:0] cmd_addr = 22'h000000;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_ready, rsp_valid, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_byte_n;
    logic flash_dq_oe, id_voltage_addr_en, id_voltage_reset_en, we_low;
    logic [15:0] rsp_data, flash_dq_in, flash_dq_out;
    logic [21:0] flash_addr, prev_addr;
    int n_errors = 0;
    int check_count = 0;
    int lo_cnt = 0;
    int rec_cnt = 0;

    always #50 clock = ~clock;

    nfc_host dut (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n),
        .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .id_voltage_addr_en(id_voltage_addr_en), .id_voltage_reset_en(id_voltage_reset_en));

    nfc_flash_model #(.MAKER(MAKER), .DEVC(DEVC), .EXT1(EXT1), .EXT2(EXT2)) flash (.addr(flash_addr),
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
        .dq_in(flash_dq_out), .hv_addr(id_voltage_addr_en), .dq(flash_dq_in));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask

    function automatic logic [15:0] pat(input logic [21:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction

    task automatic wait_idle();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic issue(input nfc_pkg::nfc_op_t op, input logic [21:0] a, input logic [15:0] d);
        @(negedge clock);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        wait_idle();
        check_bit(cmd_ready, 1'b1);
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask

    task automatic rd(input nfc_pkg::nfc_op_t op, input logic [21:0] a, input logic [15:0] exp);
        int n;
        n = 0;
        issue(op, a, 16'h0000);
        while (rsp_valid !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        check_val(n, 32'(nfc_pkg::ACC_CYC) + 32'd1);
        check_val({16'h0000, rsp_data}, {16'h0000, exp});
    endtask

    task automatic t_array();
        rd(nfc_pkg::OP_READ, 22'h001234, pat(22'h001234));
        rd(nfc_pkg::OP_READ, 22'h001235, pat(22'h001235));
        rd(nfc_pkg::OP_READ, 22'h001237, pat(22'h001237));
        rd(nfc_pkg::OP_READ, 22'h3FFFF8, pat(22'h3FFFF8));
        $display("array read test done");
    endtask

    task automatic t_cmd_id();
        issue(nfc_pkg::OP_ID_ENTER, 22'h000000, 16'h0000);
        rd(nfc_pkg::OP_READ, 22'h000000, MAKER);
        rd(nfc_pkg::OP_READ, 22'h000001, DEVC);
        rd(nfc_pkg::OP_READ, 22'h00000E, EXT1);
        rd(nfc_pkg::OP_READ, 22'h00000F, EXT2);
        issue(nfc_pkg::OP_ID_EXIT, 22'h000000, 16'h0000);
        rd(nfc_pkg::OP_READ, 22'h000001, pat(22'h000001));
        issue(nfc_pkg::OP_ID_ENTER, 22'h000000, 16'h0000);
        issue(nfc_pkg::OP_WRITE, 22'h000000, nfc_pkg::CMD_RESET);
        rd(nfc_pkg::OP_READ, 22'h000002, pat(22'h000002));
        $display("command id test done");
    endtask

    task automatic t_hv_id();
        rd(nfc_pkg::OP_HV_READ, 22'h000000, MAKER);
        rd(nfc_pkg::OP_HV_READ, 22'h2AAAA1, DEVC);
        rd(nfc_pkg::OP_READ, 22'h000000, pat(22'h000000));
        $display("high voltage id test done");
    endtask

    task automatic t_protect();
        rd(nfc_pkg::OP_VERIFY, G5, 16'h0000);
        issue(nfc_pkg::OP_PROTECT, G5, 16'h0000);
        rd(nfc_pkg::OP_VERIFY, G5, 16'h0001);
        rd(nfc_pkg::OP_VERIFY, G6, 16'h0000);
        rd(nfc_pkg::OP_READ, G5, pat(G5));
        $display("protect test done");
    endtask

    task automatic t_unprot();
        issue(nfc_pkg::OP_UNPROT_ON, 22'h000000, 16'h0000);
        repeat (2) @(negedge clock);
        wait_idle();
        check_bit(id_voltage_reset_en, 1'b1);
        check_bit(flash_reset_n, 1'b1);
        issue(nfc_pkg::OP_UNPROT_OFF, 22'h000000, 16'h0000);
        repeat (2) @(negedge clock);
        wait_idle();
        check_bit(id_voltage_reset_en, 1'b0);
        $display("temporary unprotect test done");
    endtask

    task automatic t_hw_reset();
        issue(nfc_pkg::OP_ID_ENTER, 22'h000000, 16'h0000);
        issue(nfc_pkg::OP_HW_RESET, 22'h000000, 16'h0000);
        rd(nfc_pkg::OP_READ, 22'h000000, pat(22'h000000));
        $display("hardware reset test done");
    endtask

    // pin rules watched on every cycle while resetn is high, since they span all operations
    always @(negedge clock) begin
        if (resetn) begin
            if (!flash_we_n) begin
                check_bit(flash_ce_n, 1'b0);
                if (!id_voltage_addr_en) check_bit(flash_oe_n, 1'b1);
                if (we_low) check_val({10'h000, flash_addr}, {10'h000, prev_addr});
            end
            if (flash_dq_oe) check_bit(flash_oe_n, 1'b1);
            if (!flash_reset_n) begin
                check_bit(flash_dq_oe, 1'b0);
                lo_cnt++;
                rec_cnt = 0;
            end else begin
                if (lo_cnt > 0) check_bit(lo_cnt >= nfc_pkg::RST_CYC, 1'b1);
                lo_cnt = 0;
                if (!flash_ce_n && !flash_oe_n && rec_cnt < 50) check_bit(rec_cnt >= nfc_pkg::REC_CYC, 1'b1);
                if (rec_cnt < 1000) rec_cnt++;
            end
        end
        we_low = !flash_we_n;
        prev_addr = flash_addr;
    end

    initial begin
        #(20000 * 100);
        n_errors++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        repeat (5) @(negedge clock);
        check_bit(flash_reset_n, 1'b0);
        check_bit(flash_dq_oe, 1'b0);
        check_bit(flash_ce_n, 1'b1);
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        wait_idle();
        check_bit(flash_byte_n, 1'b1);
        t_array();
        t_cmd_id();
        t_hv_id();
        t_protect();
        t_unprot();
        t_hw_reset();
        give_verdict();
    end
endmodule
